// [logic/rtcu_defs.svh]
// encoding, width and reset constants for the rotate-through-carry unit
`ifndef RTCU_DEFS_SVH
`define RTCU_DEFS_SVH
`define RTCU_OPC_POS 8
`define RTCU_OPC_W 6
`define RTCU_OPC_RL 6'h0d
`define RTCU_OPC_RR 6'h0c
`define RTCU_DEST_POS 7
`define RTCU_ADDR_W 7
`define RTCU_DATA_W 8
`define RTCU_W_RST 8'h00
`define RTCU_C_RST 1'b0
`define RTCU_INSTR_W 14
`endif

// [logic/rtcu_pkg.sv]
// types for the rotate-through-carry unit
`include "rtcu_defs.svh"
package rtcu_pkg;
  typedef enum logic [1:0] {rtcu_decode, rtcu_read, rtcu_process, rtcu_write} rtcu_phase_e;
  typedef logic [`RTCU_DATA_W-1:0] rtcu_byte_t;
  typedef logic [`RTCU_ADDR_W-1:0] rtcu_addr_t;
endpackage

// [logic/rtcu_rotate_unit.sv]
// rotate-through-carry datapath slice with four-phase sequencing
//
// Contract
// - read addressed register, shift one place
// - left: bits up, carry in, bit7 out
// - dest zero: result into accumulator only
// - dest one: result back into source
`timescale 1ns/1ns
`include "rtcu_defs.svh"
module rtcu_rotate_unit
  import rtcu_pkg::*;
(
  input wire logic clk, // 10 mhz core clock
  input wire logic nrst, // async reset, active low
  input wire logic instr_valid, // one-cycle pulse: new instruction
  input wire logic [`RTCU_INSTR_W-1:0] instr, // instruction word
  input wire logic [`RTCU_DATA_W-1:0] file_rdata, // register file read data
  output logic busy, // instruction in flight
  output logic [`RTCU_ADDR_W-1:0] file_addr, // register file address
  output logic file_rd, // read strobe, one cycle
  output logic file_wr, // write strobe, one cycle
  output logic [`RTCU_DATA_W-1:0] file_wdata, // write data
  output logic [`RTCU_DATA_W-1:0] acc, // working accumulator
  output logic carry, // carry flag
  output logic done // pulse at write phase end
);

  // ****************************************
  // decode helpers
  // ****************************************
  // opcode check used both at decode and in the checks
  function automatic logic rtcu_is_rot(input logic [`RTCU_INSTR_W-1:0] i);
    logic [`RTCU_OPC_W-1:0] op;
    op = i[`RTCU_OPC_POS +: `RTCU_OPC_W];
    return (op == `RTCU_OPC_RL) || (op == `RTCU_OPC_RR);
  endfunction

  // ****************************************
  // state
  // ****************************************
  rtcu_phase_e phase_reg, phase_next;
  logic busy_reg, busy_next;
  logic left_reg, left_next;
  logic dest_reg, dest_next;
  rtcu_addr_t addr_reg, addr_next;
  rtcu_byte_t opnd_reg, opnd_next;
  rtcu_byte_t res_reg, res_next;
  logic cout_reg, cout_next;
  rtcu_byte_t acc_reg, acc_next;
  logic c_reg, c_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  rtcu_byte_t wdata_reg, wdata_next;
  logic done_reg, done_next;

  // phase sequencing and datapath; non-rotate opcodes are ignored since other blocks own them
  always_comb begin
    phase_next = phase_reg;
    busy_next = busy_reg;
    left_next = left_reg;
    dest_next = dest_reg;
    addr_next = addr_reg;
    opnd_next = opnd_reg;
    res_next = res_reg;
    cout_next = cout_reg;
    acc_next = acc_reg;
    c_next = c_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    wdata_next = wdata_reg;
    done_next = 1'b0;
    case (phase_reg)
      rtcu_decode: begin
        if (instr_valid && rtcu_is_rot(instr)) begin
          left_next = (instr[`RTCU_OPC_POS +: `RTCU_OPC_W] == `RTCU_OPC_RL);
          dest_next = instr[`RTCU_DEST_POS];
          addr_next = instr[`RTCU_ADDR_W-1:0];
          rd_next = 1'b1;
          busy_next = 1'b1;
          phase_next = rtcu_read;
        end
      end
      rtcu_read: begin
        // operand sampled at the end of the read-strobe cycle
        opnd_next = file_rdata;
        phase_next = rtcu_process;
      end
      rtcu_process: begin
        if (left_reg) begin
          res_next = {opnd_reg[`RTCU_DATA_W-2:0], c_reg};
          cout_next = opnd_reg[`RTCU_DATA_W-1];
        end else begin
          res_next = {c_reg, opnd_reg[`RTCU_DATA_W-1:1]};
          cout_next = opnd_reg[0];
        end
        phase_next = rtcu_write;
      end
      rtcu_write: begin
        c_next = cout_reg;
        if (dest_reg) begin
          wr_next = 1'b1;
          wdata_next = res_reg;
        end else begin
          acc_next = res_reg;
        end
        done_next = 1'b1;
        busy_next = 1'b0;
        phase_next = rtcu_decode;
      end
      default: begin
        phase_next = rtcu_decode;
        busy_next = 1'b0;
      end
    endcase
  end

  // registers only; reset values are constants
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= rtcu_decode;
      busy_reg <= 1'b0;
      left_reg <= 1'b0;
      dest_reg <= 1'b0;
      addr_reg <= '0;
      opnd_reg <= '0;
      res_reg <= '0;
      cout_reg <= 1'b0;
      acc_reg <= `RTCU_W_RST;
      c_reg <= `RTCU_C_RST;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      busy_reg <= busy_next;
      left_reg <= left_next;
      dest_reg <= dest_next;
      addr_reg <= addr_next;
      opnd_reg <= opnd_next;
      res_reg <= res_next;
      cout_reg <= cout_next;
      acc_reg <= acc_next;
      c_reg <= c_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
      done_reg <= done_next;
    end
  end

  // outputs straight from flops
  assign busy = busy_reg;
  assign file_addr = addr_reg;
  assign file_rd = rd_reg;
  assign file_wr = wr_reg;
  assign file_wdata = wdata_reg;
  assign acc = acc_reg;
  assign carry = c_reg;
  assign done = done_reg;

  // ****************************************
  // checks
  // ****************************************
  sequence s_accept;
    (phase_reg == rtcu_decode) && instr_valid && rtcu_is_rot(instr);
  endsequence

  // done is registered in the write phase, so it shows on the fourth edge after accept
  sequence s_finish;
    ##4 done;
  endsequence

  property p_read_addr;
    @(posedge clk) disable iff (!nrst)
      s_accept |=> file_rd && (file_addr == $past(instr[`RTCU_ADDR_W-1:0]));
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("read strobe or address wrong");

  property p_left;
    @(posedge clk) disable iff (!nrst)
      s_accept ##0 (instr[`RTCU_OPC_POS +: `RTCU_OPC_W] == `RTCU_OPC_RL) ##1 1'b1 |->
        ##3 carry == $past(file_rdata[`RTCU_DATA_W-1], 3);
  endproperty
  a_left: assert property (p_left) else $error("left rotate carry wrong");

  property p_left_res;
    @(posedge clk) disable iff (!nrst)
      (phase_reg == rtcu_write) && left_reg |-> res_reg == {$past(opnd_reg[`RTCU_DATA_W-2:0]), carry};
  endproperty
  a_left_res: assert property (p_left_res) else $error("left rotate result wrong");

  property p_right_res;
    @(posedge clk) disable iff (!nrst)
      (phase_reg == rtcu_write) && !left_reg |->
        (res_reg == {carry, $past(opnd_reg[`RTCU_DATA_W-1:1])}) && (cout_reg == $past(opnd_reg[0]));
  endproperty
  a_right_res: assert property (p_right_res) else $error("right rotate result wrong");

  property p_dest_acc;
    @(posedge clk) disable iff (!nrst)
      (phase_reg == rtcu_write) && !dest_reg |=> !file_wr && (acc == $past(res_reg));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong");

  property p_dest_file;
    @(posedge clk) disable iff (!nrst)
      (phase_reg == rtcu_write) && dest_reg |=> file_wr && (file_wdata == $past(res_reg)) && $stable(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_latency;
    @(posedge clk) disable iff (!nrst)
      s_accept |-> s_finish;
  endproperty
  a_latency: assert property (p_latency) else $error("done not four cycles after accept");

  property p_carry_hold;
    @(posedge clk) disable iff (!nrst)
      !done |-> $stable(carry);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved outside write");

endmodule // rtcu_rotate_unit

// [test/tb_top.sv]
// self-checking bench for the rotate-through-carry unit
`timescale 1ns/1ns
`include "rtcu_defs.svh"
module tb_top
  import rtcu_pkg::*;
;
  logic clk, nrst, instr_valid, busy, file_rd, file_wr, carry, done, exp_c;
  logic [`RTCU_INSTR_W-1:0] instr;
  rtcu_addr_t file_addr;
  rtcu_byte_t file_rdata, file_wdata, acc, exp_acc;
  int err_count, cmp_count;

  rtcu_rotate_unit i_dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .busy(busy), .file_addr(file_addr), .file_rd(file_rd),
    .file_wr(file_wr), .file_wdata(file_wdata), .acc(acc), .carry(carry), .done(done));

  // 100 ns period core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string name, input logic [7:0] seen, input logic [7:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one rotate; poke offers a stray instruction while busy, which must be ignored
  task op(input logic left, input logic d, input rtcu_addr_t a, input rtcu_byte_t v, input logic poke);
    rtcu_byte_t res;
    logic nc;
    int n;
    res = left ? {v[6:0], exp_c} : {exp_c, v[7:1]};
    nc = left ? v[7] : v[0];
    instr_valid = 1'b1;
    instr = {(left ? `RTCU_OPC_RL : `RTCU_OPC_RR), d, a};
    file_rdata = ~v; // wrong value outside the read slot
    @(negedge clk);
    instr_valid = 1'b0;
    chk("file_rd", file_rd, 8'h01);
    chk("file_addr", file_addr, a);
    chk("busy", busy, 8'h01);
    // operand must stand in the read-strobe cycle
    file_rdata = v;
    @(negedge clk);
    chk("file_rd_pulse", file_rd, 8'h00);
    file_rdata = ~v;
    instr_valid = poke;
    instr = {`RTCU_OPC_RL, ~d, ~a};
    n = 0;
    while (done !== 1'b1 && n < 8) begin
      @(negedge clk);
      instr_valid = 1'b0;
      n++;
    end
    chk("latency", n[7:0], 8'h02);
    if (n == 8) print_verdict;
    chk("carry", carry, nc);
    chk("acc", acc, d ? exp_acc : res);
    chk("file_wr", file_wr, d);
    if (d) chk("file_wdata", file_wdata, res);
    exp_c = nc;
    if (!d) exp_acc = res;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_left_acc;
    op(1'b1, 1'b0, 7'h00, 8'he6, 1'b0);
    op(1'b1, 1'b0, 7'h2a, 8'h80, 1'b0);
    $display("test left_acc done");
  endtask

  task t_right_file;
    op(1'b0, 1'b1, 7'h7f, 8'h01, 1'b0);
    op(1'b0, 1'b1, 7'h55, 8'h02, 1'b0);
    $display("test right_file done");
  endtask

  // back-to-back with stray requests while busy
  task t_busy;
    op(1'b1, 1'b1, 7'h33, 8'h7f, 1'b1);
    op(1'b0, 1'b0, 7'h44, 8'h00, 1'b1);
    op(1'b1, 1'b0, 7'h01, 8'h81, 1'b0);
    $display("test busy done");
  endtask

  // a non-rotate opcode must start nothing
  task t_ignored;
    instr_valid = 1'b1;
    instr = {6'h07, 1'b1, 7'h11};
    @(negedge clk);
    instr_valid = 1'b0;
    repeat (5) begin
      @(negedge clk);
      chk("rd_idle", {file_rd, done, busy}, 8'h00);
    end
    chk("acc_kept", acc, exp_acc);
    chk("carry_kept", carry, exp_c);
    $display("test ignored done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    file_rdata = 8'h00;
    exp_acc = 8'h00;
    exp_c = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    chk("acc_rst", acc, 8'h00);
    chk("carry_rst", carry, 8'h00);
    t_left_acc;
    t_right_file;
    t_busy;
    t_ignored;
    print_verdict;
  end
endmodule // tb_top
